//--- rtl/vdrp_defs.svh
/*
 Timing counts and pin widths of the random-port controller.
 Assumes a 100 MHz controller clock; definitions only.
*/
`ifndef VDRP_DEFS_SVH
`define VDRP_DEFS_SVH
`define VDRP_ADDR_W      9
`define VDRP_DATA_W      4
`define VDRP_SETUP_NS    20
`define VDRP_STROBE_NS   60
`define VDRP_PRECH_NS    80
`define VDRP_CLK_NS      10
`define VDRP_SETUP_CYC   ((`VDRP_SETUP_NS + `VDRP_CLK_NS - 1) / `VDRP_CLK_NS)
`define VDRP_STROBE_CYC  ((`VDRP_STROBE_NS + `VDRP_CLK_NS - 1) / `VDRP_CLK_NS)
`define VDRP_PRECH_CYC   ((`VDRP_PRECH_NS + `VDRP_CLK_NS - 1) / `VDRP_CLK_NS)
`endif

//--- rtl/vdrp_pkg.sv
/*
 Types of the random-port controller.
 Assumes vdrp_defs.svh for numeric constants.
*/
package vdrp_pkg;
   typedef enum logic [2:0] {
      READ,        // Plain read
      WRITE,       // Write, optional lane mask
      BLOCK_WR,    // Four-column block write
      LOAD_COLOR,  // Colour register load
      XFER_WR,     // Serial register into row
      XFER_WR_ALT, // Serial register into row, shift gate ignored
      XFER_RD      // Row into serial register
   } vdrp_cmd_t;
endpackage : vdrp_pkg

//--- rtl/vdrp_pins_if.sv
/*
 Pin bundle between the sequencer and its pin timer.
 Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`include "vdrp_defs.svh"
interface vdrp_pins_if;
   logic                    tick;    // Timing step pulse
   logic                    busy;    // Timer counting
   logic [7:0]              load;    // Cycles to count
   logic                    start;   // Start pulse
   modport seq (output load, output start, input tick, input busy);
   modport tmr (input load, input start, output tick, output busy);
endinterface : vdrp_pins_if

//--- rtl/vdrp_timer.sv
/*
 Down counter giving a one-cycle step pulse after a loaded delay.
 Assumes a synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "vdrp_defs.svh"
module vdrp_timer (
   input  wire logic clock,        // 100 MHz clock
   input  wire logic nrst,         // Sync reset, active low
   vdrp_pins_if.tmr  tp            // Timer side
);
   logic [7:0] count_r;
   always_ff @(posedge clock)
   begin
      if (!nrst)
         count_r <= 8'h00;
      else if (tp.start)
         count_r <= tp.load;
      else if (count_r != 8'h00)
         count_r <= count_r - 8'h01;
   end
   assign tp.busy = (count_r != 8'h00);
   assign tp.tick = (count_r == 8'h01);
endmodule : vdrp_timer

//--- rtl/vdrp_host.sv
/*
 Controller driving the random port of a dual-ported video DRAM.
 Assumes the device answers asynchronously; read data is sampled
 through three flip-flops. No clock or reset on the device side.
*/
`timescale 1ns/100ps
`include "vdrp_defs.svh"
module vdrp_host #(
   parameter int ADDR_W = `VDRP_ADDR_W,
   parameter int DATA_W = `VDRP_DATA_W
) (
   input  wire logic               clock,      // 100 MHz clock
   input  wire logic               nrst,       // Sync reset, active low
   input  wire logic               reqValid,   // Command request
   input  wire vdrp_pkg::vdrp_cmd_t reqCmd,    // Cycle type
   input  wire logic [ADDR_W-1:0]  reqRow,     // Row address
   input  wire logic [ADDR_W-1:0]  reqCol,     // Column or tap address
   input  wire logic [DATA_W-1:0]  reqData,    // Write or colour data
   input  wire logic [DATA_W-1:0]  reqMask,    // Lane mask for write and block write
   input  wire logic               reqMaskEn,  // Use lane mask
   input  wire logic               reqShiftIn, // Shift gate level
   output logic                    reqReady,   // Idle, takes request
   output logic                    rspValid,   // Read data pulse
   output logic [DATA_W-1:0]       rspData,    // Read data
   output logic                    rowStrobe_n,   // Row strobe
   output logic                    colStrobe_n,   // Column strobe
   output logic                    writeStrobe_n, // Write strobe
   output logic                    transfer_gate_n,         // Gate
   output logic                    special_function_select, // Fn
   output logic                    shift_port_gate_n,       // Shift gate
   output logic [ADDR_W-1:0]       multiplexed_address_pins, // Address
   output logic [DATA_W-1:0]       random_io_lines_o,  // Data out
   output logic                    random_io_lines_oe, // Drive enable
   input  wire logic [DATA_W-1:0]  random_io_lines_i   // Data in
);
   localparam logic [7:0] SETUP  = 8'(`VDRP_SETUP_CYC);
   localparam logic [7:0] STROBE = 8'(`VDRP_STROBE_CYC);
   localparam logic [7:0] PRECH  = 8'(`VDRP_PRECH_CYC);

   typedef enum logic [2:0] {
      IDLE, ROW_SET, ROW_HOLD, COL_HOLD, GATE_OFF, DATA_WR, PRECH_ST
   } vdrp_state_t;

   vdrp_pins_if tp ();
   vdrp_timer u_timer (.clock(clock), .nrst(nrst), .tp(tp));

   vdrp_state_t         state_r;
   vdrp_pkg::vdrp_cmd_t cmd_r;
   logic [ADDR_W-1:0]   col_r;
   logic [DATA_W-1:0]   data_r;
   logic [DATA_W-1:0]   syncA_r, syncB_r, syncC_r;
   logic                take;

   function automatic logic isXfer(input vdrp_pkg::vdrp_cmd_t c);
      isXfer = (c == vdrp_pkg::XFER_WR) || (c == vdrp_pkg::XFER_WR_ALT)
            || (c == vdrp_pkg::XFER_RD);
   endfunction : isXfer

   function automatic logic isWrite(input vdrp_pkg::vdrp_cmd_t c);
      isWrite = (c != vdrp_pkg::READ) && (c != vdrp_pkg::XFER_RD);
   endfunction : isWrite

   function automatic logic hasMask(input vdrp_pkg::vdrp_cmd_t c);
      hasMask = (c == vdrp_pkg::WRITE) || (c == vdrp_pkg::BLOCK_WR);
   endfunction : hasMask

   // Read data synchroniser
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         syncA_r <= 4'h0;
         syncB_r <= 4'h0;
         syncC_r <= 4'h0;
      end
      else
      begin
         syncA_r <= random_io_lines_i;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end

   // A request waits until the strobes have been high for the precharge
   assign take     = (state_r == IDLE) && reqValid && !tp.busy;
   assign tp.start = (state_r != IDLE) && tp.tick || take;
   // Length of the phase that follows each state
   always_comb
   begin
      case (state_r)
         IDLE:     tp.load = SETUP;
         ROW_SET:  tp.load = STROBE;
         ROW_HOLD: tp.load = STROBE;
         COL_HOLD: tp.load = STROBE;
         GATE_OFF: tp.load = STROBE;
         DATA_WR:  tp.load = SETUP;
         PRECH_ST: tp.load = PRECH;
         default:  tp.load = SETUP;
      endcase
   end

   // Sequencer
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         state_r <= IDLE;
         cmd_r   <= vdrp_pkg::READ;
         col_r   <= '0;
         data_r  <= '0;
      end
      else
      begin
         case (state_r)
            IDLE:
               if (take)
               begin
                  state_r <= ROW_SET;
                  cmd_r   <= reqCmd;
                  col_r   <= reqCol;
                  data_r  <= reqData;
               end
            ROW_SET:  if (tp.tick) state_r <= ROW_HOLD;
            ROW_HOLD: if (tp.tick) state_r <= COL_HOLD;
            COL_HOLD:
               if (tp.tick)
                  state_r <= isXfer(cmd_r) ? PRECH_ST : GATE_OFF;
            GATE_OFF:
               if (tp.tick)
                  state_r <= isWrite(cmd_r) ? DATA_WR : PRECH_ST;
            DATA_WR:  if (tp.tick) state_r <= PRECH_ST;
            PRECH_ST: if (tp.tick) state_r <= IDLE;
            default:  state_r <= IDLE;
         endcase
      end
   end

   // Pin drive
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         rowStrobe_n              <= 1'b1;
         colStrobe_n              <= 1'b1;
         writeStrobe_n            <= 1'b1;
         transfer_gate_n          <= 1'b1;
         special_function_select  <= 1'b0;
         shift_port_gate_n        <= 1'b1;
         multiplexed_address_pins <= '0;
         random_io_lines_o        <= '0;
         random_io_lines_oe       <= 1'b0;
      end
      else if (take)
      begin
         // Levels settle before the row strobe falls
         multiplexed_address_pins <= reqRow;
         transfer_gate_n <= !isXfer(reqCmd);
         writeStrobe_n <= !(reqCmd == vdrp_pkg::XFER_WR
            || reqCmd == vdrp_pkg::XFER_WR_ALT
            || (reqMaskEn && hasMask(reqCmd)));
         special_function_select <= (reqCmd == vdrp_pkg::LOAD_COLOR)
            || (reqCmd == vdrp_pkg::XFER_WR_ALT);
         shift_port_gate_n <= !(reqCmd == vdrp_pkg::XFER_WR)
            && reqShiftIn;
         random_io_lines_o  <= reqMask;
         random_io_lines_oe <= reqMaskEn && hasMask(reqCmd);
      end
      else if (tp.tick)
      begin
         case (state_r)
            ROW_SET:
               rowStrobe_n <= 1'b0;
            ROW_HOLD:
            begin
               multiplexed_address_pins <= col_r;
               special_function_select <= (cmd_r == vdrp_pkg::LOAD_COLOR)
                  || (cmd_r == vdrp_pkg::BLOCK_WR);
               writeStrobe_n      <= 1'b1;
               random_io_lines_oe <= 1'b0;
               // Gate low on reads opens the device drivers
               if (cmd_r == vdrp_pkg::READ)
                  transfer_gate_n <= 1'b0;
            end
            COL_HOLD:
            begin
               colStrobe_n <= 1'b0;
               // Reads keep the gate low so the device can answer
               if (cmd_r != vdrp_pkg::READ)
                  transfer_gate_n <= 1'b1;
               // Write data goes up while the gate holds the device off
               if (isWrite(cmd_r) && !isXfer(cmd_r))
               begin
                  random_io_lines_o  <= data_r;
                  random_io_lines_oe <= 1'b1;
               end
            end
            GATE_OFF:
            begin
               // Read data is taken at this edge, then the device is shut
               transfer_gate_n <= 1'b1;
               if (isWrite(cmd_r))
                  writeStrobe_n <= 1'b0;
            end
            DATA_WR:
               writeStrobe_n <= 1'b1;
            PRECH_ST:
            begin
               rowStrobe_n             <= 1'b1;
               colStrobe_n             <= 1'b1;
               transfer_gate_n         <= 1'b1;
               special_function_select <= 1'b0;
               shift_port_gate_n       <= 1'b1;
               random_io_lines_oe      <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // Read capture while column strobe and gate are low
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         rspValid <= 1'b0;
         rspData  <= '0;
      end
      else
      begin
         rspValid <= (state_r == GATE_OFF) && tp.tick
                     && (cmd_r == vdrp_pkg::READ);
         if ((state_r == GATE_OFF) && tp.tick && (cmd_r == vdrp_pkg::READ))
            rspData <= syncC_r;
      end
   end

   // Ready once idle and the precharge count has run out
   always_ff @(posedge clock)
   begin
      if (!nrst)
         reqReady <= 1'b0;
      else
         reqReady <= (state_r == IDLE) && !take
                     && (!tp.busy || tp.tick);
   end

   sequence rowFallMasked;
      $fell(rowStrobe_n) && !writeStrobe_n && !isXfer(cmd_r);
   endsequence

   sequence colFallRead;
      $fell(colStrobe_n) && (cmd_r == vdrp_pkg::READ);
   endsequence

   chk_row_idle_float: assert property (
      @(posedge clock) disable iff (!nrst)
      rowStrobe_n && random_io_lines_oe |-> !writeStrobe_n)
      else $error("data driven while row strobe high without mask");
   chk_gate_before_drive: assert property (
      @(posedge clock) disable iff (!nrst)
      $rose(random_io_lines_oe) && !rowStrobe_n |-> transfer_gate_n)
      else $error("write data driven with gate low");
   chk_xfer_no_drive: assert property (
      @(posedge clock) disable iff (!nrst)
      !rowStrobe_n && isXfer(cmd_r) |-> !random_io_lines_oe)
      else $error("data driven during transfer");
   chk_colour_fn: assert property (
      @(posedge clock) disable iff (!nrst)
      $fell(colStrobe_n) && cmd_r == vdrp_pkg::LOAD_COLOR
      |-> special_function_select)
      else $error("colour load without function select");
   chk_addr_stable: assert property (
      @(posedge clock) disable iff (!nrst)
      $fell(rowStrobe_n) |-> $stable(multiplexed_address_pins))
      else $error("address moved at row strobe fall");
   chk_mask_at_row: assert property (
      @(posedge clock) disable iff (!nrst)
      rowFallMasked |-> random_io_lines_oe)
      else $error("write mask not driven at row strobe fall");
   chk_read_gate_low: assert property (
      @(posedge clock) disable iff (!nrst)
      colFallRead |-> !transfer_gate_n)
      else $error("read column strobe with gate high");
endmodule : vdrp_host

//--- sim/vdrp_dev_model.sv
/*
 Behavioural random port of the video DRAM facing the controller.
 Assumes strobes arrive asynchronously; the model has no clock.
*/
`timescale 1ns/100ps
module vdrp_dev_model (
   input  wire logic       rowN,   // Row strobe
   input  wire logic       colN,   // Column strobe
   input  wire logic       wrN,    // Write strobe
   input  wire logic       gateN,  // Transfer gate
   input  wire logic       sfs,    // Function select
   input  wire logic       shiftN, // Shift gate
   input  wire logic [8:0] addr,   // Address pins
   input  wire logic [3:0] dq,     // Data lines
   output logic      [3:0] qOut,   // Read data
   output logic            qOe     // Model drives data lines
);
   logic [3:0] mem [int];
   logic [3:0] ser [512];
   logic [8:0] row;
   logic [8:0] col;
   logic       rGate;
   logic       rSfs;
   logic       cSfs;
   logic [3:0] wMask;
   logic [3:0] colour;
   int         xferKind;
   function automatic logic [3:0] rd(logic [8:0] r, logic [8:0] c);
      return mem.exists(int'({r, c})) ? mem[int'({r, c})] : 4'h0;
   endfunction : rd
   task automatic put(logic [8:0] c, logic [3:0] v);
      mem[int'({row, c})] = (v & wMask) | (rd(row, c) & ~wMask);
   endtask : put
   task automatic store(logic [3:0] d);
      if (!rGate) return;
      if (rSfs && cSfs) colour = d;
      else if (!cSfs) put(col, d);
      else for (int i = 0; i < 4; i++)
         if (d[i]) put({col[8:2], i[1:0]}, colour);
   endtask : store
   // Output float while row, column or gate strobe is high, write strobe is low, or a transfer runs
   assign qOe = !rowN && !colN && !gateN && rGate
                && wrN;
   always @(negedge rowN)
   begin
      row = addr;
      rGate = gateN;
      rSfs = sfs;
      wMask = wrN ? 4'hF : dq;
      xferKind = 0;
      if (!gateN && !wrN && sfs) xferKind = 2;
      else if (!gateN && !wrN && !shiftN) xferKind = 1;
      else if (!gateN && wrN && !sfs) xferKind = 3;
      for (int i = 0; i < 512; i++)
      begin
         if (xferKind == 3) ser[i] = rd(row, i[8:0]);
         else if (xferKind != 0) mem[int'({row, i[8:0]})] = ser[i];
      end
   end
   always @(negedge colN)
   begin
      if (!rowN)
      begin
         col = addr;
         cSfs = sfs;
         qOut = rd(row, col);
         if (!wrN) store(dq);
      end
   end
   always @(negedge wrN)
   begin
      #1;
      if (!rowN && !colN) store(dq);
   end
endmodule : vdrp_dev_model

//--- sim/tb_video_dram_random_port.sv
/*
 Self-checking bench of the random-port controller.
 Assumes the device model on the far side of the pins.
*/
`timescale 1ns/100ps
module tb_video_dram_random_port;
   logic                clock;
   logic                nrst;
   logic                reqValid;
   logic                reqMaskEn;
   logic                reqShiftIn;
   vdrp_pkg::vdrp_cmd_t reqCmd;
   logic [8:0]          reqRow;
   logic [8:0]          reqCol;
   logic [3:0]          reqData;
   logic [3:0]          reqMask;
   logic                reqReady;
   logic                rspValid;
   logic [3:0]          rspData;
   logic                rowN;
   logic                colN;
   logic                wrN;
   logic                gateN;
   logic                sfs;
   logic                shiftN;
   logic [8:0]          addr;
   logic [3:0]          dutO;
   logic                dutOe;
   logic [3:0]          devQ;
   logic                devOe;
   logic [3:0]          ioBus;
   logic [3:0]          floatV = 4'h0;
   logic [3:0]          got;
   int                  n_fail = 0;
   int                  checks_done = 0;
   assign ioBus = dutOe ? dutO : (devOe ? devQ : floatV);
   always @(posedge clock) floatV <= ~ioBus;
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   vdrp_host dut (.clock(clock), .nrst(nrst), .reqValid(reqValid),
      .reqCmd(reqCmd), .reqRow(reqRow), .reqCol(reqCol),
      .reqData(reqData), .reqMask(reqMask), .reqMaskEn(reqMaskEn),
      .reqShiftIn(reqShiftIn), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .rowStrobe_n(rowN), .colStrobe_n(colN),
      .writeStrobe_n(wrN), .transfer_gate_n(gateN),
      .special_function_select(sfs), .shift_port_gate_n(shiftN),
      .multiplexed_address_pins(addr), .random_io_lines_o(dutO),
      .random_io_lines_oe(dutOe), .random_io_lines_i(ioBus));
   vdrp_dev_model dev (.rowN(rowN), .colN(colN), .wrN(wrN), .gateN(gateN),
      .sfs(sfs), .shiftN(shiftN), .addr(addr), .dq(ioBus), .qOut(devQ),
      .qOe(devOe));
   always @(posedge clock)
      if (dutOe === 1'b1 && devOe === 1'b1)
      begin
         $display("Error bus owner expected one seen two");
         n_fail++;
      end
   task automatic results();
      $display("Comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   task automatic chk(string what, logic [3:0] exp, logic [3:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask : chk
   task automatic waitReady();
      int n;
      n = 0;
      do
      begin
         @(negedge clock);
         if (rspValid === 1'b1) got = rspData;
         n++;
         if (n > 300) chk("ready wait", 4'h1, 4'h0);
         if (n > 300) results();
      end while (reqReady !== 1'b1);
   endtask : waitReady
   task automatic req(vdrp_pkg::vdrp_cmd_t c, logic [8:0] r, logic [8:0] cl,
                      logic [3:0] d, logic [3:0] m, logic me, logic sh);
      waitReady();
      @(posedge clock);
      reqCmd <= c;
      reqRow <= r;
      reqCol <= cl;
      reqData <= d;
      reqMask <= m;
      reqMaskEn <= me;
      reqShiftIn <= sh;
      reqValid <= 1'b1;
      @(posedge clock);
      reqValid <= 1'b0;
      waitReady();
   endtask : req
   task automatic wr(logic [8:0] r, logic [8:0] c, logic [3:0] d,
                     logic [3:0] m, logic me);
      req(vdrp_pkg::WRITE, r, c, d, m, me, 1'b1);
   endtask : wr
   task automatic rdChk(string w, logic [8:0] r, logic [8:0] c,
                        logic [3:0] exp);
      got = 4'hX;
      req(vdrp_pkg::READ, r, c, 4'h0, 4'h0, 1'b0, 1'b1);
      chk(w, exp, got);
   endtask : rdChk
   task automatic t_plain();
      wr(9'h005, 9'h009, 4'hA, 4'h0, 1'b0);
      wr(9'h005, 9'h00A, 4'h5, 4'h0, 1'b0);
      rdChk("plain word 0", 9'h005, 9'h009, 4'hA);
      rdChk("plain word 1", 9'h005, 9'h00A, 4'h5);
      $display("Test plain done");
   endtask : t_plain
   task automatic t_mask();
      wr(9'h006, 9'h014, 4'hF, 4'h0, 1'b0);
      wr(9'h006, 9'h014, 4'h0, 4'h5, 1'b1);
      rdChk("masked word", 9'h006, 9'h014, 4'hA);
      $display("Test mask done");
   endtask : t_mask
   task automatic t_block();
      for (int i = 0; i < 4; i++)
         wr(9'h007, 9'h1F0 + 9'(i), 4'h9, 4'h0, 1'b0);
      req(vdrp_pkg::LOAD_COLOR, 9'h000, 9'h000, 4'h6, 4'h0, 1'b0, 1'b1);
      wr(9'h008, 9'h000, 4'h3, 4'h0, 1'b0);
      req(vdrp_pkg::BLOCK_WR, 9'h007, 9'h1F3, 4'hA, 4'h0, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++)
         rdChk("block column", 9'h007, 9'h1F0 + 9'(i),
               i[0] ? 4'h6 : 4'h9);
      $display("Test block done");
   endtask : t_block
   task automatic t_xfer();
      wr(9'h01E, 9'h004, 4'hC, 4'h0, 1'b0);
      req(vdrp_pkg::XFER_RD, 9'h01E, 9'h000, 4'h0, 4'h0, 1'b0, 1'b1);
      chk("row to serial", 4'h3, dev.xferKind[3:0]);
      req(vdrp_pkg::XFER_WR, 9'h01F, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0);
      chk("serial to row", 4'h1, dev.xferKind[3:0]);
      rdChk("copied word", 9'h01F, 9'h004, 4'hC);
      req(vdrp_pkg::XFER_WR_ALT, 9'h01F, 9'h000, 4'h0, 4'h0, 1'b0, 1'b1);
      chk("alternate transfer", 4'h2, dev.xferKind[3:0]);
      $display("Test transfer done");
   endtask : t_xfer
   initial
   begin
      nrst = 1'b0;
      reqValid = 1'b0;
      reqCmd = vdrp_pkg::READ;
      reqRow = 9'h000;
      reqCol = 9'h000;
      reqData = 4'h0;
      reqMask = 4'h0;
      reqMaskEn = 1'b0;
      reqShiftIn = 1'b1;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      chk("idle strobes", 4'hF, {rowN, colN, wrN, gateN});
      t_plain();
      t_mask();
      t_block();
      t_xfer();
      results();
   end
endmodule : tb_video_dram_random_port
